// file: hdl/diskette_host_defs.vh
// Purpose: constants for the double sided diskette drive controller
// Assumes: 100 MHz system clock, Avalon-MM word registers
// Notes: all drive pins are active low; register offsets are word indices (address bits 4:2)
`ifndef DISKETTE_HOST_DEFS_VH
`define DISKETTE_HOST_DEFS_VH

// ==========================================================
// register map
`define REG_CTRL 3'h0
`define REG_CMD 3'h1
`define REG_STATUS 3'h2
`define REG_TXDATA 3'h3
`define REG_INDEX 3'h4
`define REG_TRACK 3'h5
`define REG_READ 3'h6

// ==========================================================
// field positions
`define CTRL_SELECT 0
`define CTRL_MOTOR 1
`define CTRL_SIDE 2
`define CTRL_DIR_OUT 3
`define CMD_STEP 0
`define CMD_WRITE 1
`define ST_REFUSED 9
`define CTRL_RESET 4'h0
`define TRACK_MAX 6'd39

// ==========================================================
// timing
`define CLK_MHZ 100
`define MOTOR_WAIT_MS 750
`define MOTOR_WAIT_CYC (`MOTOR_WAIT_MS * 1000 * `CLK_MHZ)
`define ERASE_WAIT_MS 1
`define ERASE_WAIT_CYC (`ERASE_WAIT_MS * 1000 * `CLK_MHZ)
`define HEAD_WAIT_US 100
`define HEAD_WAIT_CYC (`HEAD_WAIT_US * `CLK_MHZ)
`define SETTLE_MS 6
`define SETTLE_CYC (`SETTLE_MS * 1000 * `CLK_MHZ)
`define DIR_MARGIN_US 1
`define DIR_MARGIN_CYC (`DIR_MARGIN_US * `CLK_MHZ + 1)
`define STEP_WIDTH_US 1
`define STEP_WIDTH_CYC (`STEP_WIDTH_US * `CLK_MHZ)
`define WR_PULSE_NS 250
`define WR_PULSE_CYC ((`WR_PULSE_NS * `CLK_MHZ + 999) / 1000)
`define GATE_MARGIN_US 6
`define GATE_MARGIN_CYC (`GATE_MARGIN_US * `CLK_MHZ)
`define SPACE4_US 4
`define SPACE6_US 6
`define SPACE8_US 8
`define SPACE4_CYC (`SPACE4_US * `CLK_MHZ)
`define SPACE6_CYC (`SPACE6_US * `CLK_MHZ)
`define SPACE8_CYC (`SPACE8_US * `CLK_MHZ)
`define FIFO_DEPTH 8
`define FIFO_AW 3
`define FIFO_WIDTH 2

`endif

// file: hdl/cell_fifo.v
// Purpose: small synchronous fifo for write cell codes
// Assumes: single clock, ce freezes all state
// Notes: out_data is valid combinationally while out_valid is high
`timescale 1ns/100ps
module cell_fifo #(
  parameter WIDTH = 2,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk_sys,
  input wire rstn,
  input wire ce,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge clk_sys) begin
    if (ce && push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else if (ce) begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // cell_fifo

// file: hdl/diskette_host.v
// Purpose: controller that drives a double sided diskette drive over its pins
// Assumes: one drive on select line 0; software paces reads from the read register
// Notes: pin changes that the drive must see settled are applied only while idle
//
// The address map and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/100ps
`include "diskette_host_defs.vh"
module diskette_host #(
  parameter [26:0] MOTOR_WAIT_CYC = `MOTOR_WAIT_CYC,
  parameter [16:0] ERASE_WAIT_CYC = `ERASE_WAIT_CYC,
  parameter [13:0] HEAD_WAIT_CYC = `HEAD_WAIT_CYC,
  parameter [19:0] SETTLE_CYC = `SETTLE_CYC
) (
  input wire clk_sys,
  input wire rstn,
  input wire ce,
  input wire [4:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output reg waitrequest,
  output reg drive_select_n,
  output reg motor_on_n,
  output reg direction_n,
  output reg step_n,
  output reg write_data_n,
  output reg write_gate_n,
  output reg side_select_n,
  input wire index_n,
  input wire track0_n,
  input wire write_protect_n,
  input wire read_data_n
);
  // ==========================================================
  // states and derived counts
  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_STEP_SETUP = 4'h1;
  localparam [3:0] S_STEP_PULSE = 4'h2;
  localparam [3:0] S_STEP_HOLD = 4'h3;
  localparam [3:0] S_STEP_SETTLE = 4'h4;
  localparam [3:0] S_WR_LEAD = 4'h5;
  localparam [3:0] S_WR_PULSE = 4'h6;
  localparam [3:0] S_WR_GAP = 4'h7;
  localparam [3:0] S_WR_TAIL = 4'h8;
  localparam [19:0] DIR_MARGIN = `DIR_MARGIN_CYC;
  localparam [19:0] STEP_WIDTH = `STEP_WIDTH_CYC;
  localparam [19:0] WR_PULSE = `WR_PULSE_CYC;
  localparam [19:0] GATE_MARGIN = `GATE_MARGIN_CYC;
  localparam [19:0] SPACE4 = `SPACE4_CYC;
  localparam [19:0] SPACE6 = `SPACE6_CYC;
  localparam [19:0] SPACE8 = `SPACE8_CYC;

  // ==========================================================
  // pin synchronisers
  reg [3:0] sync1;
  reg [3:0] sync2;
  reg [3:0] sync3;
  wire [3:0] pins_in;
  assign pins_in = {read_data_n, write_protect_n, track0_n, index_n};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          sync1[gi] <= 1'b1;
          sync2[gi] <= 1'b1;
          sync3[gi] <= 1'b1;
        end else if (ce) begin
          sync1[gi] <= pins_in[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
        end
      end
    end
  endgenerate

  // drive outputs are low active and float high when deselected
  wire index_fall = sync3[0] & ~sync2[0];
  wire at_track0 = ~sync2[1];
  wire wp_active = ~sync2[2];
  wire read_fall = sync3[3] & ~sync2[3];

  // ==========================================================
  // state
  reg [3:0] state;
  reg [19:0] tcnt;
  reg [3:0] ctrl;
  reg cmd_step;
  reg cmd_write;
  reg refused;
  reg refuse_pulse;
  reg [5:0] track;
  reg [1:0] cur_space;
  reg [26:0] motor_cnt;
  reg [16:0] erase_cnt;
  reg [13:0] head_cnt;
  reg [7:0] index_count;
  reg [15:0] read_count;
  reg [15:0] read_gap;
  reg [15:0] read_last;
  reg [31:0] rd_mux;

  wire selected = ~drive_select_n;
  wire motor_ready = (motor_cnt == MOTOR_WAIT_CYC);
  wire head_ready = (head_cnt == 14'd0);
  wire erasing = (erase_cnt != 17'd0);
  // a side change not yet on the pin has not started its head wait
  wire side_pending = (side_select_n != ~ctrl[`CTRL_SIDE]);
  wire busy = (state != S_IDLE);
  wire tdone = (tcnt == 20'd0);
  wire [2:0] reg_sel = address[4:2];
  wire req = (read | write) & waitrequest;
  wire is_tx = write & (reg_sel == `REG_TXDATA);
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [1:0] fifo_out_data;
  // a full fifo stalls the bus by holding waitrequest
  wire go = req & (~is_tx | fifo_in_ready);
  wire fifo_pop = ((state == S_WR_LEAD) || (state == S_WR_GAP)) && tdone && fifo_out_valid;

  function [19:0] space_cyc;
    input [1:0] code;
    begin
      case (code)
        2'h0: space_cyc = SPACE4;
        2'h1: space_cyc = SPACE6;
        default: space_cyc = SPACE8;
      endcase
    end
  endfunction

  cell_fifo #(
    .WIDTH(`FIFO_WIDTH),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .ce(ce),
    .in_valid(req & is_tx),
    .in_ready(fifo_in_ready),
    .in_data(writedata[1:0]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop & ce),
    .out_data(fifo_out_data)
  );

  // ==========================================================
  // register bus
  always @* begin
    rd_mux = 32'h0;
    case (reg_sel)
      `REG_CTRL: rd_mux = {28'h0, ctrl};
      `REG_STATUS: rd_mux = {22'h0, refused, ~fifo_out_valid, ~fifo_in_ready, erasing,
                             head_ready, motor_ready, ~sync2[0], wp_active, at_track0, busy};
      `REG_INDEX: rd_mux = {24'h0, index_count};
      `REG_TRACK: rd_mux = {26'h0, track};
      `REG_READ: rd_mux = {read_last, read_count};
      default: rd_mux = 32'h0;
    endcase
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      waitrequest <= 1'b1;
      readdata <= 32'h0;
      ctrl <= `CTRL_RESET;
      cmd_step <= 1'b0;
      cmd_write <= 1'b0;
      refused <= 1'b0;
    end else if (ce) begin
      waitrequest <= 1'b1;
      cmd_step <= 1'b0;
      cmd_write <= 1'b0;
      // a new refusal outweighs a clear in the same cycle
      if (go && write && reg_sel == `REG_STATUS && writedata[`ST_REFUSED]) begin
        refused <= refuse_pulse;
      end else if (refuse_pulse) begin
        refused <= 1'b1;
      end
      if (go) begin
        waitrequest <= 1'b0;
        readdata <= read ? rd_mux : 32'h0;
        if (write && reg_sel == `REG_CTRL) begin
          ctrl <= writedata[3:0];
        end
        if (write && reg_sel == `REG_CMD) begin
          cmd_step <= writedata[`CMD_STEP];
          cmd_write <= writedata[`CMD_WRITE];
        end
      end
    end
  end

  // ==========================================================
  // motor timer that gates writes, and index and read counters that count whether or not the motor is on
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      motor_cnt <= 27'd0;
      index_count <= 8'h0;
      read_count <= 16'h0;
      read_gap <= 16'h0;
      read_last <= 16'h0;
    end else if (ce) begin
      if (motor_on_n) begin
        motor_cnt <= 27'd0;
      end else if (!motor_ready) begin
        motor_cnt <= motor_cnt + 27'd1;
      end
      if (index_fall) begin
        index_count <= index_count + 8'h1;
      end
      // read spacing is measured in cycles and saturates
      if (read_fall) begin
        read_count <= read_count + 16'h1;
        read_last <= read_gap;
        read_gap <= 16'h0;
      end else if (read_gap != 16'hffff) begin
        read_gap <= read_gap + 16'h1;
      end
    end
  end

  // ==========================================================
  // sequencer
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state <= S_IDLE;
      tcnt <= 20'd0;
      track <= 6'd0;
      cur_space <= 2'h0;
      erase_cnt <= 17'd0;
      head_cnt <= 14'd0;
      refuse_pulse <= 1'b0;
      drive_select_n <= 1'b1;
      motor_on_n <= 1'b1;
      direction_n <= 1'b1;
      step_n <= 1'b1;
      write_data_n <= 1'b1;
      write_gate_n <= 1'b1;
      side_select_n <= 1'b1;
    end else if (ce) begin
      refuse_pulse <= 1'b0;
      if (!tdone) begin
        tcnt <= tcnt - 20'd1;
      end
      if (erasing) begin
        erase_cnt <= erase_cnt - 17'd1;
      end
      if (!head_ready) begin
        head_cnt <= head_cnt - 14'd1;
      end
      // the flag lags a step by the synchroniser, so only idle cycles may resync the count
      if (at_track0 && !busy) begin
        track <= 6'd0;
      end
      case (state)
        S_IDLE: begin
          // select, motor and side wait for erase to finish
          if (!erasing) begin
            drive_select_n <= ~ctrl[`CTRL_SELECT];
            motor_on_n <= ~ctrl[`CTRL_MOTOR];
            if (side_select_n != ~ctrl[`CTRL_SIDE]) begin
              side_select_n <= ~ctrl[`CTRL_SIDE];
              head_cnt <= HEAD_WAIT_CYC;
            end
          end
          if (cmd_step) begin
            if (!selected || (ctrl[`CTRL_DIR_OUT] && at_track0) ||
                (!ctrl[`CTRL_DIR_OUT] && track == `TRACK_MAX)) begin
              refuse_pulse <= 1'b1;
            end else begin
              direction_n <= ~ctrl[`CTRL_DIR_OUT];
              tcnt <= DIR_MARGIN - 20'd1;
              state <= S_STEP_SETUP;
            end
          end else if (cmd_write) begin
            if (!selected || !motor_ready || !head_ready || side_pending ||
                wp_active || erasing) begin
              refuse_pulse <= 1'b1;
            end else begin
              write_gate_n <= 1'b0;
              tcnt <= GATE_MARGIN - 20'd1;
              state <= S_WR_LEAD;
            end
          end
        end
        S_STEP_SETUP: begin
          if (tdone) begin
            step_n <= 1'b0;
            tcnt <= STEP_WIDTH - 20'd1;
            state <= S_STEP_PULSE;
          end
        end
        S_STEP_PULSE: begin
          if (tdone) begin
            step_n <= 1'b1;
            if (!direction_n) begin
              if (track != 6'd0) begin
                track <= track - 6'd1;
              end
            end else begin
              track <= track + 6'd1;
            end
            tcnt <= DIR_MARGIN - 20'd1;
            state <= S_STEP_HOLD;
          end
        end
        S_STEP_HOLD: begin
          // direction stays put here and until the next step
          if (tdone) begin
            tcnt <= SETTLE_CYC - 20'd1;
            state <= S_STEP_SETTLE;
          end
        end
        S_STEP_SETTLE: begin
          if (tdone) begin
            state <= S_IDLE;
          end
        end
        S_WR_LEAD, S_WR_GAP: begin
          if (tdone) begin
            if (fifo_out_valid) begin
              cur_space <= fifo_out_data;
              write_data_n <= 1'b0;
              tcnt <= WR_PULSE - 20'd1;
              state <= S_WR_PULSE;
            end else begin
              // an empty fifo ends the write; software keeps it topped up
              tcnt <= GATE_MARGIN - 20'd1;
              state <= S_WR_TAIL;
            end
          end
        end
        S_WR_PULSE: begin
          if (tdone) begin
            write_data_n <= 1'b1;
            tcnt <= space_cyc(cur_space) - WR_PULSE - 20'd1;
            state <= S_WR_GAP;
          end
        end
        S_WR_TAIL: begin
          if (tdone) begin
            write_gate_n <= 1'b1;
            erase_cnt <= ERASE_WAIT_CYC;
            state <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end
endmodule // diskette_host

// file: test/diskette_host_properties.sv
// Purpose: port-level checks of the diskette controller
// Assumes: ce held high, so cycle counts are real time
// Notes: bound to every diskette_host instance
`timescale 1ns/100ps
module diskette_host_properties #(
  parameter [26:0] MOTOR_WAIT_CYC = 27'd200,
  parameter [16:0] ERASE_WAIT_CYC = 17'd50,
  parameter [13:0] HEAD_WAIT_CYC = 14'd30,
  parameter [19:0] SETTLE_CYC = 20'd20
) (
  input wire clk_sys, rstn, ce, read, write, waitrequest,
  input wire [4:0] address,
  input wire [31:0] writedata, readdata,
  input wire drive_select_n, motor_on_n, direction_n, step_n,
  input wire write_data_n, write_gate_n, side_select_n,
  input wire index_n, track0_n, write_protect_n, read_data_n
);
  // ==========
  // elapsed-cycle counters; all but low_step and low_wr saturate so long idle spells never wrap
  reg [7:0] low_step, since_dir, since_step;
  reg [4:0] low_wr;
  reg [16:0] erase_left;
  reg [26:0] motor_up;
  reg [13:0] since_side;
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      low_step <= 8'h00;
      since_dir <= 8'hff;
      since_step <= 8'hff;
      low_wr <= 5'h00;
      erase_left <= 17'h0;
      motor_up <= 27'h0;
      since_side <= HEAD_WAIT_CYC;
    end else begin
      low_step <= step_n ? 8'h00 : low_step + 8'h01;
      low_wr <= write_data_n ? 5'h00 : low_wr + 5'h01;
      since_dir <= $changed(direction_n) ? 8'h00 : since_dir + {7'h0, since_dir != 8'hff};
      since_step <= !step_n ? 8'h00 : since_step + {7'h0, since_step != 8'hff};
      // loaded one short: a change exactly one erase time later is legal
      erase_left <= $rose(write_gate_n) ? ERASE_WAIT_CYC - 17'h1 :
        erase_left - {16'h0, erase_left != 17'h0};
      motor_up <= motor_on_n ? 27'h0 : motor_up + {26'h0, motor_up != MOTOR_WAIT_CYC};
      since_side <= $changed(side_select_n) ? 14'h0 :
        since_side + {13'h0, since_side != HEAD_WAIT_CYC};
    end
  end

  // ==========
  // assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_gate_on;
    $fell(write_gate_n);
  endsequence
  sequence s_step_end;
    $rose(step_n);
  endsequence
  a_wait_single: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_step_width: assert property (s_step_end |-> low_step == 8'd100)
    else $error("step pulse not 100 cycles");
  a_dir_before: assert property ($fell(step_n) |-> since_dir >= 8'd99)
    else $error("direction changed too close before step");
  a_dir_after: assert property ($changed(direction_n) |-> since_step >= 8'd100)
    else $error("direction changed during or too soon after step");
  a_step_selected: assert property ($fell(step_n) |-> !drive_select_n)
    else $error("step issued to a deselected drive");
  a_write_width: assert property ($rose(write_data_n) |-> low_wr == 5'd25)
    else $error("write pulse not 25 cycles");
  a_write_gated: assert property (!write_data_n |-> !write_gate_n)
    else $error("write pulse outside write gate");
  a_erase_hold: assert property (erase_left != 17'h0 |->
    $stable(drive_select_n) && $stable(motor_on_n) && $stable(side_select_n))
    else $error("select, motor or side changed while erasing");
  a_motor_ready: assert property (s_gate_on |-> motor_up >= MOTOR_WAIT_CYC)
    else $error("write started before motor wait");
  a_head_ready: assert property (s_gate_on |-> since_side >= HEAD_WAIT_CYC - 14'd1)
    else $error("write started before head wait");
endmodule // diskette_host_properties

bind diskette_host diskette_host_properties #(.MOTOR_WAIT_CYC(MOTOR_WAIT_CYC),
  .ERASE_WAIT_CYC(ERASE_WAIT_CYC), .HEAD_WAIT_CYC(HEAD_WAIT_CYC), .SETTLE_CYC(SETTLE_CYC))
  u_props (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .read(read), .write(write),
  .waitrequest(waitrequest), .address(address), .writedata(writedata), .readdata(readdata),
  .drive_select_n(drive_select_n), .motor_on_n(motor_on_n), .direction_n(direction_n),
  .step_n(step_n), .write_data_n(write_data_n), .write_gate_n(write_gate_n),
  .side_select_n(side_select_n), .index_n(index_n), .track0_n(track0_n),
  .write_protect_n(write_protect_n), .read_data_n(read_data_n));

// file: test/drive_model.sv
// Purpose: behavioural double sided diskette drive
// Assumes: pins active low, drive reacts at once
// Notes: released outputs read high, as the host pull-ups make them
`timescale 1ns/100ps
module drive_model (
  input wire drive_select_n, motor_on_n, direction_n, step_n,
  input wire write_data_n, write_gate_n, side_select_n,
  input wire protect, index_go, read_go,
  output wire index_n, track0_n, write_protect_n, read_data_n,
  output integer track, bits, head
);
  reg idx = 1'b1;
  reg rdp = 1'b1;
  wire on = (drive_select_n === 1'b0);
  assign index_n = on ? idx : 1'b1;
  assign track0_n = on ? (track != 0) : 1'b1;
  assign write_protect_n = on ? !protect : 1'b1;
  assign read_data_n = on ? rdp : 1'b1;
  always @* head = side_select_n ? 0 : 1;
  initial begin
    track = 0;
    bits = 0;
  end
  // head moves on the trailing edge only
  always @(posedge step_n) begin
    if (on && !direction_n && track > 0) track = track - 1;
    else if (on && direction_n === 1'b1) track = track + 1;
  end
  always @(negedge write_data_n) if (on && !write_gate_n && !protect) bits = bits + 1;
  // pins move just off the clock edge so the host samples them without a race
  always @(posedge index_go) begin
    #1 idx = 1'b0;
    #3000 idx = 1'b1;
  end
  always @(posedge read_go) begin
    #1 rdp = 1'b0;
    #250 rdp = 1'b1;
    #3750 rdp = 1'b0;
    #250 rdp = 1'b1;
    #5750 rdp = 1'b0;
    #250 rdp = 1'b1;
  end
endmodule // drive_model

// file: test/test_diskette_host.sv
// Purpose: self-checking bench for the diskette controller
// Assumes: shortened wait parameters, ce kept high
// Notes: each register read leaves a note that the monitor compares
`timescale 1ns/100ps
`include "diskette_host_defs.vh"
module test_diskette_host;
  reg clk_sys = 1'b0;
  reg rstn = 1'b0;
  reg ce = 1'b1;
  reg [4:0] address = 5'h00;
  reg read = 1'b0;
  reg write = 1'b0;
  reg [31:0] writedata = 32'h0;
  reg protect = 1'b0;
  reg index_go = 1'b0;
  reg read_go = 1'b0;
  wire [31:0] readdata;
  wire waitrequest, drive_select_n, motor_on_n, direction_n, step_n, write_data_n;
  wire write_gate_n, side_select_n, index_n, track0_n, write_protect_n, read_data_n;
  integer track, bits, head, i, n;
  integer n_mismatch = 0;
  integer n_compared = 0;
  logic [63:0] notes[$];
  logic [63:0] note;
  logic [31:0] q;

  diskette_host #(.MOTOR_WAIT_CYC(27'd200), .ERASE_WAIT_CYC(17'd50), .HEAD_WAIT_CYC(14'd30),
    .SETTLE_CYC(20'd20)) dut (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .drive_select_n(drive_select_n), .motor_on_n(motor_on_n),
    .direction_n(direction_n), .step_n(step_n), .write_data_n(write_data_n),
    .write_gate_n(write_gate_n), .side_select_n(side_select_n), .index_n(index_n),
    .track0_n(track0_n), .write_protect_n(write_protect_n), .read_data_n(read_data_n));
  drive_model drive (.drive_select_n(drive_select_n), .motor_on_n(motor_on_n),
    .direction_n(direction_n), .step_n(step_n), .write_data_n(write_data_n),
    .write_gate_n(write_gate_n), .side_select_n(side_select_n), .protect(protect),
    .index_go(index_go), .read_go(read_go), .index_n(index_n), .track0_n(track0_n),
    .write_protect_n(write_protect_n), .read_data_n(read_data_n), .track(track),
    .bits(bits), .head(head));

  initial forever #5 clk_sys = ~clk_sys;

  // ==========
  // checking and bus tasks
  task automatic check(input string what, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
    integer k;
    @(posedge clk_sys);
    address <= {a, 2'b00};
    writedata <= d;
    write <= w;
    read <= !w;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (waitrequest !== 1'b0 && k < 2000);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0) begin
      check("bus answer", {31'h0, waitrequest}, 32'h0);
      wrap_up();
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [2:0] a, input logic [31:0] m, e);
    notes.push_back({m, e});
    bus(1'b0, a, 32'h0);
  endtask
  task automatic poll(input logic [2:0] a, input logic [31:0] m, v);
    integer k;
    k = 0;
    do begin
      rd(a, 32'h0, 32'h0);
      k++;
    end while ((q & m) !== v && k < 5000);
    check("poll", q & m, v);
    if ((q & m) !== v) wrap_up();
  endtask
  task automatic run_cmd(input logic [31:0] c);
    wr(`REG_CMD, c);
    poll(`REG_STATUS, 32'h1, 32'h1);
    poll(`REG_STATUS, 32'h1, 32'h0);
  endtask

  // takes the oldest note whenever read data are answered
  always @(posedge clk_sys) begin
    if (read === 1'b1 && waitrequest === 1'b0) begin
      note = notes.pop_front();
      check("readdata", readdata & note[63:32], note[31:0]);
    end
  end

  // ==========
  // scenarios
  initial begin
    void'($urandom(99457));
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    check("idle pins", {25'h0, drive_select_n, motor_on_n, direction_n, step_n,
      write_data_n, write_gate_n, side_select_n}, 32'h7f);
    rd(`REG_CTRL, 32'hf, 32'h0);
    rd(3'h7, 32'hffffffff, 32'h0);
    wr(3'h7, 32'h5);
    wr(`REG_CTRL, 32'h9);
    rd(`REG_CTRL, 32'hf, 32'h9);
    check("select dir", {30'h0, drive_select_n, direction_n}, 32'h1);
    wr(`REG_CMD, 32'h1);
    poll(`REG_STATUS, 32'h200, 32'h200);
    check("track zero", track, 0);
    wr(`REG_STATUS, 32'h200);
    rd(`REG_STATUS, 32'h200, 32'h0);
    n = 1 + $urandom % 3;
    wr(`REG_CTRL, 32'h1);
    for (i = 0; i < n; i++) run_cmd(32'h1);
    check("track in", track, n);
    rd(`REG_TRACK, 32'h3f, n);
    rd(`REG_STATUS, 32'h2, 32'h0);
    wr(`REG_CTRL, 32'h9);
    run_cmd(32'h1);
    check("track out", track, n - 1);
    check("dir out", {31'h0, direction_n}, 32'h0);
    wr(`REG_CMD, 32'h2);
    poll(`REG_STATUS, 32'h200, 32'h200);
    wr(`REG_STATUS, 32'h200);
    wr(`REG_CTRL, 32'h3);
    for (i = 0; i < 8; i++) wr(`REG_TXDATA, $urandom % 4);
    rd(`REG_STATUS, 32'h180, 32'h80);
    poll(`REG_STATUS, 32'h10, 32'h10);
    run_cmd(32'h2);
    poll(`REG_STATUS, 32'h40, 32'h0);
    check("bits", bits, 8);
    rd(`REG_STATUS, 32'h180, 32'h100);
    wr(`REG_CTRL, 32'h7);
    wr(`REG_TXDATA, 32'h0);
    wr(`REG_CMD, 32'h2);
    poll(`REG_STATUS, 32'h200, 32'h200);
    check("head", head, 1);
    wr(`REG_STATUS, 32'h200);
    poll(`REG_STATUS, 32'h20, 32'h20);
    protect <= 1'b1;
    poll(`REG_STATUS, 32'h4, 32'h4);
    wr(`REG_CMD, 32'h2);
    poll(`REG_STATUS, 32'h200, 32'h200);
    check("bits kept", bits, 8);
    protect <= 1'b0;
    for (i = 0; i < 3; i++) begin
      if (i == 2) wr(`REG_CTRL, 32'h0);
      if (i == 2) rd(`REG_CTRL, 32'hf, 32'h0);
      index_go <= 1'b1;
      repeat (400) @(posedge clk_sys);
      index_go <= 1'b0;
      @(posedge clk_sys);
      if (i == 1) poll(`REG_INDEX, 32'hff, 32'h2);
    end
    rd(`REG_INDEX, 32'hff, 32'h2);
    protect <= 1'b1;
    @(posedge clk_sys);
    check("released", {30'h0, write_protect_n, track0_n}, 32'h3);
    protect <= 1'b0;
    wr(`REG_CTRL, 32'h1);
    read_go <= 1'b1;
    poll(`REG_READ, 32'hffff, 32'h3);
    rd(`REG_READ, 32'hffff0000, 32'h02570000);
    wrap_up();
  end
endmodule // test_diskette_host
